// ### src/usb_cfg_dev.sv
`timescale 1ns/10ps
module usb_cfg_dev (
	// Clock and reset.
	input  wire logic        i_clk_sys,
	input  wire logic        i_srst,
	// Command link.
	usb_cfg_if.dev           link,
	// Bus and event inputs.
	input  wire logic        i_bus_reset,
	input  wire logic [31:0] i_event_set,
	input  wire logic [31:0] i_event_clear,
	// DMA engine side.
	input  wire logic [15:0] i_dma_count,
	input  wire logic        i_dma_byte_done,
	input  wire logic        i_short_out_packet,
	// Outputs.
	output logic             o_irq,
	output logic             o_dma_run,
	output logic             o_dma_reload,
	output logic             o_dma_abort,
	output logic             o_eot,
	output logic [3:0]       o_dma_endpoint,
	output logic [4:0]       o_burst_bytes,
	output logic [15:0]      o_byte_count
);
	import usb_cfg_pkg::*;

	// ****************************************
	// Command decode
	// ****************************************
	logic [7:0]  cmd_code;
	logic [1:0]  byte_idx;
	logic [31:0] shadow;
	logic [31:0] interrupt_enable_mask;
	logic [15:0] dma_configuration;
	logic        dma_run;
	logic [31:0] pending;
	logic [15:0] byte_count;
	logic        mask_commit;
	logic        dma_commit;
	logic [15:0] next_dma_cfg;
	logic [31:0] read_word;
	logic        dma_start;
	logic        dma_stop_write;
	logic        reach_zero;
	logic        eot_cond;

	// Every data byte advances the index; the command phase resets it.
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			cmd_code <= 8'h00;
			byte_idx <= 2'h0;
		end else if (link.cmd_strobe) begin
			cmd_code <= link.wdata;
			byte_idx <= 2'h0;
		end else if (link.wr_strobe || link.rd_strobe) begin
			byte_idx <= byte_idx + 2'h1;
		end
	end

	// Written bytes collect here, lowest byte first, until the last arrives.
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			shadow <= 32'h00000000;
		end else if (link.wr_strobe) begin
			shadow[{byte_idx, 3'h0} +: 8] <= link.wdata;
		end
	end

	assign mask_commit = link.wr_strobe && (cmd_code == CMD_WR_IRQ_MASK)
		&& ({1'b0, byte_idx} == LEN_IRQ_MASK - 3'h1);
	assign dma_commit = link.wr_strobe && (cmd_code == CMD_WR_DMA_CFG)
		&& ({1'b0, byte_idx} == LEN_DMA_CFG - 3'h1);
	assign next_dma_cfg = {link.wdata, shadow[7:0]};

	// ****************************************
	// Interrupt enable mask
	// ****************************************
	// A bus reset does not touch the mask; only hardware reset clears it.
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			interrupt_enable_mask <= IRQ_MASK_RESET;
		end else if (mask_commit) begin
			interrupt_enable_mask <= {link.wdata, shadow[23:0]};
		end
	end

	// Pending events are sticky; a set in the cycle of its clear wins.
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			pending <= 32'h00000000;
		end else begin
			pending <= (pending & ~i_event_clear) | (i_event_set & IRQ_MASK_USED);
		end
	end

	// Each event position is gated by the mask bit at the same position.
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(pending & interrupt_enable_mask & IRQ_MASK_USED);
		end
	end

	// ****************************************
	// DMA configuration
	// ****************************************
	assign dma_start      = dma_commit && next_dma_cfg[POS_DMA_RUN] && !dma_run;
	assign dma_stop_write = dma_commit && !next_dma_cfg[POS_DMA_RUN] && dma_run;
	assign reach_zero     = dma_run && i_dma_byte_done && (byte_count == 16'h0001);
	assign eot_cond = (dma_configuration[POS_COUNTER_END] && reach_zero)
		|| (dma_configuration[POS_SHORT_MODE] && dma_run && i_short_out_packet);

	// The stored copy keeps all bits, the run bit too; the live run bit lives apart in dma_run.
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			dma_configuration <= DMA_CFG_RESET;
		end else if (dma_commit) begin
			dma_configuration <= next_dma_cfg;
		end
	end

	// Bus reset wins over a write in the same cycle and stops DMA.
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			dma_run <= 1'b0;
		end else if (i_bus_reset) begin
			dma_run <= 1'b0;
		end else if (dma_commit) begin
			dma_run <= next_dma_cfg[POS_DMA_RUN];
		end else if (eot_cond) begin
			dma_run <= 1'b0;
		end
	end

	// The counter reloads whenever DMA goes from stopped to running.
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			byte_count <= 16'h0000;
		end else if (dma_start && !i_bus_reset) begin
			byte_count <= i_dma_count;
		end else if (dma_run && i_dma_byte_done && (byte_count != 16'h0000)) begin
			byte_count <= byte_count - 16'h0001;
		end
	end

	// Event pulses towards the DMA engine.
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_dma_reload <= 1'b0;
			o_dma_abort  <= 1'b0;
			o_eot        <= 1'b0;
		end else begin
			o_dma_reload <= dma_start && !i_bus_reset;
			o_dma_abort  <= dma_stop_write && !i_bus_reset;
			o_eot        <= eot_cond && !i_bus_reset && !dma_commit;
		end
	end

	// Decoded configuration outputs.
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_dma_endpoint <= 4'h0;
			o_burst_bytes  <= BURST_BYTES_1;
			o_dma_run      <= 1'b0;
			o_byte_count   <= 16'h0000;
		end else begin
			o_dma_endpoint <= dma_configuration[POS_ENDPOINT_SEL +: 4];
			o_dma_run      <= dma_run;
			o_byte_count   <= byte_count;
			unique case (dma_configuration[POS_BURST_SEL +: 2])
				BURST_SINGLE: o_burst_bytes <= BURST_BYTES_1;
				BURST_FOUR:   o_burst_bytes <= BURST_BYTES_4;
				BURST_EIGHT:  o_burst_bytes <= BURST_BYTES_8;
				default:      o_burst_bytes <= BURST_BYTES_16;
			endcase
		end
	end

	// ****************************************
	// Read data
	// ****************************************
	// The run bit reads back live, so an end of transfer shows as zero.
	always_comb begin
		read_word = 32'h00000000;
		if (cmd_code == CMD_RD_IRQ_MASK) begin
			read_word = interrupt_enable_mask;
		end else if (cmd_code == CMD_RD_DMA_CFG) begin
			read_word[15:0]        = dma_configuration;
			read_word[POS_DMA_RUN] = dma_run;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			link.rdata <= 8'h00;
		end else if (link.rd_strobe) begin
			link.rdata <= read_word[{byte_idx, 3'h0} +: 8];
		end
	end

endmodule

// ### common/usb_cfg_pkg.sv
package usb_cfg_pkg;

	// ****************************************
	// Command codes and data phase lengths
	// ****************************************
	localparam logic [7:0] CMD_WR_IRQ_MASK = 8'hC2;
	localparam logic [7:0] CMD_RD_IRQ_MASK = 8'hC3;
	localparam logic [7:0] CMD_WR_DMA_CFG  = 8'hF0;
	localparam logic [7:0] CMD_RD_DMA_CFG  = 8'hF1;
	localparam logic [2:0] LEN_IRQ_MASK    = 3'h4;
	localparam logic [2:0] LEN_DMA_CFG     = 3'h2;

	// ****************************************
	// Interrupt enable mask layout
	// ****************************************
	localparam logic [31:0] IRQ_MASK_RESET     = 32'h00000000;
	localparam logic [31:0] IRQ_MASK_USED      = 32'h00FFFF7F;
	localparam logic [31:0] IRQ_MASK_RSVD_HIGH = 32'hFF000000;
	localparam int          POS_ENDPOINT_LO    = 10;
	localparam int          POS_CTRL_IN        = 9;
	localparam int          POS_CTRL_OUT       = 8;
	localparam int          POS_SHORT_PACKET   = 6;
	localparam int          POS_PSEUDO_FRAME   = 5;
	localparam int          POS_FRAME_START    = 4;
	localparam int          POS_TRANSFER_END   = 3;
	localparam int          POS_SUSPEND        = 2;
	localparam int          POS_RESUME         = 1;
	localparam int          POS_BUS_RESET      = 0;

	// ****************************************
	// DMA configuration layout
	// ****************************************
	localparam logic [15:0] DMA_CFG_RESET       = 16'h0000;
	localparam int          POS_COUNTER_END     = 15;
	localparam int          POS_SHORT_MODE      = 14;
	localparam int          POS_ENDPOINT_SEL    = 4;
	localparam int          POS_DMA_RUN         = 3;
	localparam int          POS_BURST_SEL       = 0;
	localparam logic [1:0]  BURST_SINGLE        = 2'h0;
	localparam logic [1:0]  BURST_FOUR          = 2'h1;
	localparam logic [1:0]  BURST_EIGHT         = 2'h2;
	localparam logic [4:0]  BURST_BYTES_1       = 5'h01;
	localparam logic [4:0]  BURST_BYTES_4       = 5'h04;
	localparam logic [4:0]  BURST_BYTES_8       = 5'h08;
	localparam logic [4:0]  BURST_BYTES_16      = 5'h10;

	// ****************************************
	// Host controller register offsets
	// ****************************************
	localparam logic [7:0] OFS_COMMAND = 8'h00;
	localparam logic [7:0] OFS_WDATA   = 8'h04;
	localparam logic [7:0] OFS_RDATA   = 8'h08;
	localparam logic [7:0] OFS_STATUS  = 8'h0C;
	localparam int         POS_IN_DIR  = 8;

endpackage

// ### common/usb_cfg_if.sv
`timescale 1ns/10ps
interface usb_cfg_if;
	logic       cmd_strobe;
	logic       wr_strobe;
	logic       rd_strobe;
	logic [7:0] wdata;
	logic [7:0] rdata;

	modport host (
		output cmd_strobe,
		output wr_strobe,
		output rd_strobe,
		output wdata,
		input  rdata
	);

	modport dev (
		input  cmd_strobe,
		input  wr_strobe,
		input  rd_strobe,
		input  wdata,
		output rdata
	);
endinterface

// ### src/usb_cfg_host.sv
`timescale 1ns/10ps
module usb_cfg_host (
	// Clock and reset.
	input  wire logic        i_clk_sys,
	input  wire logic        i_srst,
	// Wishbone slave.
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [7:0]  i_wb_adr,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic [31:0] i_wb_dat,
	output logic [31:0]      o_wb_dat,
	output logic             o_wb_ack,
	// Command link.
	usb_cfg_if.host          link
);
	import usb_cfg_pkg::*;

	typedef enum {ST_IDLE, ST_CMD, ST_STROBE, ST_GAP} host_state_type;

	host_state_type state;
	logic [31:0]    wdata_reg;
	logic [31:0]    tx_word;
	logic [31:0]    rx_word;
	logic [7:0]     code;
	logic [2:0]     len;
	logic [1:0]     idx;
	logic           is_read;
	logic           wb_take;
	logic           start;
	logic [31:0]    next_tx;
	logic [2:0]     next_len;

	// ****************************************
	// Wishbone slave
	// ****************************************
	assign wb_take = i_wb_cyc && i_wb_stb && o_wb_ack;
	assign start = wb_take && i_wb_we && (i_wb_adr == OFS_COMMAND) && i_wb_sel[0] && (state == ST_IDLE);

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_wb_ack <= 1'b0;
		end else begin
			o_wb_ack <= i_wb_cyc && i_wb_stb && !o_wb_ack;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			wdata_reg <= 32'h00000000;
		end else if (wb_take && i_wb_we && (i_wb_adr == OFS_WDATA)) begin
			for (int b = 0; b < 4; b++) begin
				if (i_wb_sel[b]) begin
					wdata_reg[8 * b +: 8] <= i_wb_dat[8 * b +: 8];
				end
			end
		end
	end

	// Read data is registered in the request cycle, so it stands while ack is high.
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_wb_dat <= 32'h00000000;
		end else if (i_wb_cyc && i_wb_stb && !o_wb_ack) begin
			unique case (i_wb_adr)
				OFS_COMMAND: o_wb_dat <= {24'h000000, code};
				OFS_WDATA:   o_wb_dat <= wdata_reg;
				OFS_RDATA:   o_wb_dat <= rx_word;
				OFS_STATUS:  o_wb_dat <= {31'h00000000, state != ST_IDLE};
				default:     o_wb_dat <= 32'h00000000;
			endcase
		end
	end

	// ****************************************
	// Transaction shaping
	// ****************************************
	always_comb begin
		next_tx  = wdata_reg;
		next_len = 3'h0;
		unique case (i_wb_dat[7:0])
			CMD_WR_IRQ_MASK: begin
				next_tx  = wdata_reg & ~IRQ_MASK_RSVD_HIGH;
				next_len = LEN_IRQ_MASK;
			end
			CMD_RD_IRQ_MASK: next_len = LEN_IRQ_MASK;
			CMD_WR_DMA_CFG: begin
				next_len = LEN_DMA_CFG;
				if (i_wb_dat[POS_IN_DIR]) begin
					next_tx[POS_SHORT_MODE] = 1'b0;
				end
			end
			CMD_RD_DMA_CFG: next_len = LEN_DMA_CFG;
			default:        next_len = 3'h0;
		endcase
	end

	// ****************************************
	// Link sequencer
	// ****************************************
	// Each data byte takes three cycles: ST_CMD, a strobe cycle in ST_STROBE and a gap cycle in ST_GAP.
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			state           <= ST_IDLE;
			code            <= 8'h00;
			len             <= 3'h0;
			idx             <= 2'h0;
			is_read         <= 1'b0;
			tx_word         <= 32'h00000000;
			link.cmd_strobe <= 1'b0;
			link.wr_strobe  <= 1'b0;
			link.rd_strobe  <= 1'b0;
			link.wdata      <= 8'h00;
		end else begin
			link.cmd_strobe <= 1'b0;
			link.wr_strobe  <= 1'b0;
			link.rd_strobe  <= 1'b0;
			unique case (state)
				ST_IDLE: begin
					if (start) begin
						code            <= i_wb_dat[7:0];
						len             <= next_len;
						tx_word         <= next_tx;
						is_read         <= (i_wb_dat[7:0] == CMD_RD_IRQ_MASK)
							|| (i_wb_dat[7:0] == CMD_RD_DMA_CFG);
						idx             <= 2'h0;
						link.cmd_strobe <= 1'b1;
						link.wdata      <= i_wb_dat[7:0];
						state           <= ST_CMD;
					end
				end
				ST_CMD: begin
					if (len == 3'h0) begin
						state <= ST_IDLE;
					end else begin
						link.wr_strobe <= !is_read;
						link.rd_strobe <= is_read;
						link.wdata     <= tx_word[{idx, 3'h0} +: 8];
						state          <= ST_STROBE;
					end
				end
				ST_STROBE: state <= ST_GAP;
				ST_GAP: begin
					if ({1'b0, idx} == len - 3'h1) begin
						state <= ST_IDLE;
					end else begin
						idx   <= idx + 2'h1;
						state <= ST_CMD;
					end
				end
			endcase
		end
	end

	// Read bytes land in the result word, lowest byte first.
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			rx_word <= 32'h00000000;
		end else if (start && next_len != 3'h0 && ((i_wb_dat[7:0] == CMD_RD_IRQ_MASK)
			|| (i_wb_dat[7:0] == CMD_RD_DMA_CFG))) begin
			rx_word <= 32'h00000000;
		end else if (state == ST_GAP && is_read) begin
			rx_word[{idx, 3'h0} +: 8] <= link.rdata;
		end
	end

endmodule

// ### sim/usb_cfg_asserts.sv
`timescale 1ns/10ps
module usb_cfg_asserts (
	// Clock and reset.
	input  wire logic       i_clk_sys,
	input  wire logic       i_srst,
	// Link signals.
	input  wire logic       cmd_strobe,
	input  wire logic       wr_strobe,
	input  wire logic       rd_strobe,
	input  wire logic [7:0] rdata,
	// Device side.
	input  wire logic       i_bus_reset,
	input  wire logic       o_dma_run,
	input  wire logic       o_dma_reload,
	input  wire logic       o_dma_abort,
	input  wire logic       o_eot,
	input  wire logic [4:0] o_burst_bytes
);
	// ****************************************
	// Link and DMA checks
	// ****************************************
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);

	sequence stopped_s;
		##[0:1] !o_dma_run;
	endsequence

	sequence running_s;
		##[0:1] o_dma_run;
	endsequence

	AST_CMD_SINGLE: assert property (cmd_strobe |=> !cmd_strobe)
		else $error("command strobe longer than one cycle");
	AST_WR_GAP: assert property (wr_strobe |=> !wr_strobe && !cmd_strobe)
		else $error("data byte without gap");
	AST_RDATA_HOLD: assert property (!rd_strobe |=> $stable(rdata))
		else $error("read data moved without read strobe");
	AST_BURST_CODE: assert property (o_burst_bytes inside {5'h01, 5'h04, 5'h08, 5'h10})
		else $error("burst size not 1 4 8 or 16");
	AST_RELOAD_RUN: assert property (o_dma_reload |-> running_s)
		else $error("reload without running");
	AST_ABORT_STOP: assert property (o_dma_abort |-> stopped_s)
		else $error("abort left transfer running");
	AST_EOT_STOP: assert property (o_eot |-> ##1 stopped_s)
		else $error("end of transfer left transfer running");
	AST_BUS_RESET_STOP: assert property (i_bus_reset |-> ##[1:2] !o_dma_run)
		else $error("bus reset left transfer running");
endmodule

// ### sim/tb.sv
`timescale 1ns/10ps
module tb;
	import usb_cfg_pkg::*;
	logic        clk_sys   = 1'b0;
	logic        srst      = 1'b1;
	logic        cyc       = 1'b0;
	logic        stb       = 1'b0;
	logic        we        = 1'b0;
	logic [7:0]  adr       = 8'h00;
	logic [31:0] wdat      = 32'h00000000;
	logic [31:0] rd;
	logic [31:0] wb_q;
	logic [31:0] v;
	logic        ack;
	logic        bus_rst   = 1'b0;
	logic        byte_done = 1'b0;
	logic        short_pkt = 1'b0;
	logic [31:0] ev_set    = 32'h00000000;
	logic [31:0] ev_clr    = 32'h00000000;
	logic [15:0] dma_cnt   = 16'h0000;
	logic        irq, run, reload, abort, eot;
	logic [3:0]  dep;
	logic [4:0]  bb;
	logic [15:0] bcnt;
	int          err_total = 0;
	int          tests_run = 0;
	int          n_eot     = 0;
	int          n_rel     = 0;
	int          n_abt     = 0;
	int          seed      = 32'h074d202a;

	usb_cfg_if link();
	usb_cfg_host u_usb_cfg_host (.i_clk_sys(clk_sys), .i_srst(srst), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rd), .o_wb_ack(ack),
		.link(link));
	usb_cfg_dev u_usb_cfg_dev (.i_clk_sys(clk_sys), .i_srst(srst), .link(link), .i_bus_reset(bus_rst),
		.i_event_set(ev_set), .i_event_clear(ev_clr), .i_dma_count(dma_cnt), .i_dma_byte_done(byte_done),
		.i_short_out_packet(short_pkt), .o_irq(irq), .o_dma_run(run), .o_dma_reload(reload),
		.o_dma_abort(abort), .o_eot(eot), .o_dma_endpoint(dep), .o_burst_bytes(bb), .o_byte_count(bcnt));
	usb_cfg_asserts u_usb_cfg_asserts (.i_clk_sys(clk_sys), .i_srst(srst), .cmd_strobe(link.cmd_strobe),
		.wr_strobe(link.wr_strobe), .rd_strobe(link.rd_strobe), .rdata(link.rdata), .i_bus_reset(bus_rst),
		.o_dma_run(run), .o_dma_reload(reload), .o_dma_abort(abort), .o_eot(eot), .o_burst_bytes(bb));

	// ****************************************
	// Clock, pulse counters and helpers
	// ****************************************
	always #25 clk_sys = ~clk_sys;

	always @(posedge clk_sys) begin
		if (eot === 1'b1) n_eot <= n_eot + 1;
		if (reload === 1'b1) n_rel <= n_rel + 1;
		if (abort === 1'b1) n_abt <= n_abt + 1;
	end

	function automatic logic [31:0] burst(input logic [1:0] b);
		return (b == 2'h0) ? 32'h1 : 32'h1 << ({1'b0, b} + 3'h1);
	endfunction

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_sys);
		end while (ack !== 1'b1);
		wb_q = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	// Every command ends with a read of the link answer into wb_q.
	task automatic cmd(input logic [7:0] code, input logic [31:0] d, input logic in_dir = 1'b0);
		wb(1'b1, OFS_WDATA, d);
		wb(1'b1, OFS_COMMAND, {23'h0, in_dir, code});
		do begin
			wb(1'b0, OFS_STATUS, 32'h0);
		end while (wb_q[0] !== 1'b0);
		wb(1'b0, OFS_RDATA, 32'h0);
	endtask

	// Selector 0 pulses bus reset, 1 a moved byte, 2 a short OUT packet.
	task automatic pulse(input int which);
		@(posedge clk_sys);
		case (which)
			0: bus_rst <= 1'b1;
			1: byte_done <= 1'b1;
			default: short_pkt <= 1'b1;
		endcase
		@(posedge clk_sys);
		bus_rst <= 1'b0;
		byte_done <= 1'b0;
		short_pkt <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask

	task stop_test;
		if (err_total == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		repeat (20) @(posedge clk_sys);
		srst <= 1'b0;
		cmd(CMD_RD_IRQ_MASK, 32'h0);
		chk("mask_reset", wb_q, IRQ_MASK_RESET);
		cmd(CMD_RD_DMA_CFG, 32'h0);
		chk("cfg_reset", wb_q, 32'(DMA_CFG_RESET));
		repeat (6) begin
			v = $random(seed);
			cmd(CMD_WR_IRQ_MASK, v);
			cmd(CMD_RD_IRQ_MASK, 32'h0);
			chk("mask_rw", wb_q, v & 32'h00FFFFFF);
		end
		pulse(0);
		cmd(CMD_RD_IRQ_MASK, 32'h0);
		chk("mask_bus_reset", wb_q, v & 32'h00FFFFFF);
		for (int p = 0; p < 24; p++) begin
			if (p != 7) begin
				cmd(CMD_WR_IRQ_MASK, 32'h1 << p);
				ev_set <= IRQ_MASK_USED & ~(32'h1 << p);
				@(posedge clk_sys);
				ev_set <= 32'h0;
				repeat (3) @(posedge clk_sys);
				chk("irq_masked", 32'(irq), 32'h0);
				@(posedge clk_sys);
				ev_set <= 32'h1 << p;
				@(posedge clk_sys);
				ev_set <= 32'h0;
				repeat (3) @(posedge clk_sys);
				chk("irq_enabled", 32'(irq), 32'h1);
				ev_clr <= 32'hFFFFFFFF;
				@(posedge clk_sys);
				ev_clr <= 32'h0;
				repeat (3) @(posedge clk_sys);
			end
		end
		for (int b = 0; b < 4; b++) begin
			v = ($random(seed) & 32'h0000FFF4) | b;
			cmd(CMD_WR_DMA_CFG, v);
			chk("burst", 32'(bb), burst(b[1:0]));
			chk("endpoint", 32'(dep), 32'(v[7:4]));
			cmd(CMD_RD_DMA_CFG, 32'h0);
			chk("cfg_rw", wb_q, v);
		end
		cmd(CMD_WR_DMA_CFG, 32'h00004071, 1'b1);
		cmd(CMD_RD_DMA_CFG, 32'h0);
		chk("in_dir_short", wb_q, 32'h00000071);
		dma_cnt <= 16'h0003;
		cmd(CMD_WR_DMA_CFG, 32'h8009);
		chk("run_on", 32'(run), 32'h1);
		chk("count_load", 32'(bcnt), 32'h3);
		chk("reload_on", n_rel, 1);
		cmd(CMD_RD_DMA_CFG, 32'h0);
		chk("cfg_live_on", wb_q, 32'h8009);
		repeat (3) pulse(1);
		chk("eot_count", n_eot, 1);
		cmd(CMD_RD_DMA_CFG, 32'h0);
		chk("cfg_live_off", wb_q, 32'h8001);
		cmd(CMD_WR_DMA_CFG, 32'h4008);
		pulse(2);
		chk("eot_short", n_eot, 2);
		cmd(CMD_WR_DMA_CFG, 32'h0008);
		pulse(2);
		chk("eot_no_short", n_eot, 2);
		chk("run_kept", 32'(run), 32'h1);
		cmd(CMD_WR_DMA_CFG, 32'h0000);
		chk("abort", n_abt, 1);
		chk("run_off", 32'(run), 32'h0);
		cmd(CMD_WR_DMA_CFG, 32'h8A5B);
		pulse(0);
		chk("run_bus_reset", 32'(run), 32'h0);
		cmd(CMD_RD_DMA_CFG, 32'h0);
		chk("cfg_bus_reset", wb_q, 32'h8A53);
		chk("reload_total", n_rel, 4);
		stop_test();
	end

	initial begin
		repeat (40000) @(posedge clk_sys);
		err_total++;
		stop_test();
	end
endmodule
